// [pkg/kscn_pkg.sv]
// Package for the key-scan two-wire register port.
// Assumes a single 250 MHz clock domain and a synchronous active-low reset.
`default_nettype none
package kscn_pkg;
  // Bus address: fixed upper bits, strap fills A2..A1, A0 is zero
  localparam logic [3:0] KSCN_ADDR_HI = 4'h7;
  localparam logic [1:0] KSCN_STRAP_GND = 2'h0;
  localparam logic [1:0] KSCN_STRAP_VCC = 2'h1;
  localparam logic [1:0] KSCN_STRAP_SDA = 2'h2;
  localparam logic [1:0] KSCN_STRAP_SCL = 2'h3;
  // Register offsets
  localparam logic [7:0] KSCN_REG_QUEUE = 8'h00;
  localparam logic [7:0] KSCN_REG_CONFIG = 8'h01;
  localparam logic [7:0] KSCN_REG_LAST_INC = 8'h05;
  localparam logic [7:0] KSCN_REG_SLEEP = 8'h06;
  localparam int KSCN_NREG = 7;
  // Field positions and reset values
  localparam int KSCN_CFG_RUN_BIT = 7;
  localparam int KSCN_CFG_TMO_BIT = 0;
  localparam logic [7:0] KSCN_CFG_RESET = 8'h00;
  localparam logic [7:0] KSCN_SLEEP_RESET = 8'h07;
  localparam logic [7:0] KSCN_REG_RESET = 8'h00;
  localparam logic [7:0] KSCN_QUEUE_EMPTY = 8'h3f;
  // Bus timeout: 20 ms least, rounded up at the clock rate
  localparam int KSCN_CLK_MHZ = 250;
  localparam int KSCN_TMO_MS = 20;
  localparam int KSCN_TMO_CYC = KSCN_TMO_MS * 1000 * KSCN_CLK_MHZ;
  localparam int KSCN_TMO_W = 24;
  // Key matrix
  localparam int KSCN_ROWS = 8;
  localparam int KSCN_COLS = 8;
  // Bit-engine states
  typedef enum logic [2:0] {
    KSCN_IDLE, KSCN_ADDR, KSCN_ACK_RX, KSCN_RX, KSCN_TX, KSCN_ACK_TX, KSCN_WAIT
  } kscn_state_t;
endpackage
`default_nettype wire

// [pkg/kscn_wr_if.sv]
// Interface carrying the register port's restart pulse and awake level to the key sequencer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface kscn_wr_if;
  logic restart;
  logic awake;
  modport port (output restart, output awake);
  modport seq (input restart, input awake);
endinterface // kscn_wr_if
`default_nettype wire

// [src/kscn_keydet.sv]
// Current-sensed key detector with ghost-key suppression.
// Assumes key sense levels already synchronised; restart comes from the register port.
`timescale 1ns/1ps
`default_nettype none
module kscn_keydet
  import kscn_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [KSCN_ROWS*KSCN_COLS-1:0] key_sense_i,
  kscn_wr_if.seq ctl,
  output logic [KSCN_ROWS*KSCN_COLS-1:0] accepted_o,
  output logic debounce_run_o
);
  logic [KSCN_ROWS*KSCN_COLS-1:0] held_q;
  logic [KSCN_ROWS*KSCN_COLS-1:0] ghost;

  // ---------------------------------------------------------------
  // Ghost detection
  // ---------------------------------------------------------------
  // rectangle corner check
  // A new key is the third corner if two of the other three corners of
  // some rectangle are already held; such a key is not accepted.
  genvar gk;
  generate
    for (gk = 0; gk < KSCN_ROWS*KSCN_COLS; gk++)
    begin : g_key
      localparam int R = gk / KSCN_COLS;
      localparam int C = gk % KSCN_COLS;
      always_comb
      begin
        ghost[gk] = 1'b0;
        for (int r = 0; r < KSCN_ROWS; r++)
          for (int c = 0; c < KSCN_COLS; c++)
            if (r != R && c != C && (2'(held_q[R*KSCN_COLS+c]) + 2'(held_q[r*KSCN_COLS+C])
                + 2'(held_q[r*KSCN_COLS+c]) >= 2'd2))
              ghost[gk] = 1'b1;
      end
    end
  endgenerate

  // any count accepted
  // Held set tracks presses; reset by the sequencer restart or sleep
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || ctl.restart || !ctl.awake)
      held_q <= '0;
    else
      held_q <= key_sense_i & (held_q | ~ghost);
  end

  assign accepted_o = held_q;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      debounce_run_o <= 1'b0;
    else
      debounce_run_o <= ctl.awake && (|key_sense_i);
  end
endmodule // kscn_keydet
`default_nettype wire

// [src/kscn_i2c_port.sv]
// Two-wire slave register port of the key-scan controller.
// Assumes the master clocks SCL; SDA is open drain with an external pullup.
`timescale 1ns/1ps
`default_nettype none
module kscn_i2c_port
  import kscn_pkg::*;
#(
  parameter int TMO_CYC = KSCN_TMO_CYC
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_strap_pin_i,
  input wire logic strap_vcc_i,
  input wire logic [7:0] queue_data_i,
  input wire logic [KSCN_ROWS*KSCN_COLS-1:0] key_sense_i,
  output logic queue_pop_o,
  output logic awake_o,
  output logic [KSCN_ROWS*KSCN_COLS-1:0] keys_o,
  output logic debounce_run_o
);
  import kscn_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q, ad_s_q, vcc_s_q;
  logic scl_d1_q, sda_d1_q, ad_d1_q;
  logic scl_rise, scl_fall, start_c, stop_c;

  // Two flops per pin before use
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      ad_s_q <= 2'h0;
      vcc_s_q <= 2'h0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      ad_d1_q <= 1'b0;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      ad_s_q <= {ad_s_q[0], addr_strap_pin_i};
      vcc_s_q <= {vcc_s_q[0], strap_vcc_i};
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
      ad_d1_q <= ad_s_q[1];
    end
  end

  assign scl_rise = scl_s_q[1] && !scl_d1_q;
  assign scl_fall = !scl_s_q[1] && scl_d1_q;
  assign start_c = scl_s_q[1] && scl_d1_q && sda_d1_q && !sda_s_q[1];
  assign stop_c = scl_s_q[1] && scl_d1_q && !sda_d1_q && sda_s_q[1];

  // ---------------------------------------------------------------
  // Strap decode
  // ---------------------------------------------------------------
  // Strap wired to SDA falls together with SDA at START; SCL is high then
  logic [1:0] strap_q;
  logic [6:0] own_addr;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      strap_q <= KSCN_STRAP_GND;
    else if (start_c)
    begin
      if (ad_d1_q && !ad_s_q[1])
        strap_q <= KSCN_STRAP_SDA;     // Fell with SDA at START
      else if (!ad_s_q[1])
        strap_q <= KSCN_STRAP_GND;
      else if (vcc_s_q[1])
        strap_q <= KSCN_STRAP_VCC;
      else
        strap_q <= KSCN_STRAP_SCL;
    end
  end

  assign own_addr = {KSCN_ADDR_HI, strap_q, 1'b0};

  // ---------------------------------------------------------------
  // Register file and pointer
  // ---------------------------------------------------------------
  logic [7:0] regs_q [KSCN_NREG];
  logic [7:0] ptr_q;
  logic [7:0] ptr_next;
  logic [7:0] rd_data;

  always_comb
  begin
    if (ptr_q == KSCN_REG_QUEUE)
      ptr_next = KSCN_REG_QUEUE;
    else if (ptr_q == KSCN_REG_SLEEP)
      ptr_next = KSCN_REG_QUEUE;
    else if (ptr_q <= KSCN_REG_LAST_INC)
      ptr_next = ptr_q + 8'h01;
    else
      ptr_next = ptr_q;
  end

  // Read mux; queue reads come from outside
  always_comb
  begin
    if (ptr_q == KSCN_REG_QUEUE)
      rd_data = queue_data_i;
    else if (ptr_q < 8'(KSCN_NREG))
      rd_data = regs_q[ptr_q[2:0]];
    else
      rd_data = 8'h00;
  end

  // ---------------------------------------------------------------
  // Bit engine
  // ---------------------------------------------------------------
  kscn_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rw_q, first_q, wr_q, acked_q;
  logic [KSCN_TMO_W-1:0] tmo_q;
  logic tmo_en, tmo_hit;

  assign tmo_en = regs_q[KSCN_REG_CONFIG[2:0]][KSCN_CFG_TMO_BIT];
  assign tmo_hit = tmo_en && (tmo_q == KSCN_TMO_W'(TMO_CYC));

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || scl_s_q[1] || state_q == KSCN_IDLE)
      tmo_q <= '0;
    else if (!tmo_hit)
      tmo_q <= tmo_q + 1'b1;
  end

  // Byte and acknowledge sequencing
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q <= KSCN_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      wr_q <= 1'b0;
      acked_q <= 1'b0;
    end
    else if (tmo_hit)
      state_q <= KSCN_IDLE;
    else if (start_c)
    begin
      state_q <= KSCN_ADDR;
      bit_q <= 4'h0;
    end
    else if (stop_c)
      state_q <= KSCN_IDLE;
    else
    begin
      wr_q <= 1'b0;
      case (state_q)
        KSCN_ADDR, KSCN_RX:
          if (scl_rise)
          begin
            sh_q <= {sh_q[6:0], sda_s_q[1]};
            bit_q <= bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == 4'h8)
          begin
            bit_q <= 4'h0;
            if (state_q == KSCN_ADDR)
            begin
              if (sh_q[7:1] == own_addr)
              begin
                state_q <= KSCN_ACK_RX;
                rw_q <= sh_q[0];
                first_q <= 1'b1;
              end
              else
                state_q <= KSCN_WAIT;
            end
            else
            begin
              state_q <= KSCN_ACK_RX;
              wr_q <= 1'b1;
            end
          end
        KSCN_ACK_RX:
          if (scl_fall)
            state_q <= (rw_q && first_q) ? KSCN_TX : KSCN_RX;
        KSCN_TX:
          if (scl_fall)
          begin
            if (bit_q == 4'h7)
            begin
              bit_q <= 4'h0;
              state_q <= KSCN_ACK_TX;
            end
            else
              bit_q <= bit_q + 4'h1;
          end
        KSCN_ACK_TX:
          if (scl_rise)
            acked_q <= !sda_s_q[1];
          else if (scl_fall)
            state_q <= acked_q ? KSCN_TX : KSCN_WAIT;
        KSCN_WAIT: state_q <= KSCN_WAIT;
        default: state_q <= KSCN_IDLE;
      endcase
      // Command byte consumed; later bytes are data
      if (wr_q)
        first_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pointer and register updates
  // ---------------------------------------------------------------
  logic got_byte, cmd_byte, tx_done;
  assign got_byte = wr_q && !rw_q;
  assign cmd_byte = got_byte && first_q;
  assign tx_done = state_q == KSCN_ACK_TX && scl_fall;

  // same step after each burst byte
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      ptr_q <= KSCN_REG_QUEUE;
    else if (cmd_byte)
      ptr_q <= sh_q;
    else if ((got_byte && !first_q) || tx_done)
      ptr_q <= ptr_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < KSCN_NREG; i++)
        regs_q[i] <= KSCN_REG_RESET;
      regs_q[KSCN_REG_CONFIG[2:0]] <= KSCN_CFG_RESET;
      regs_q[KSCN_REG_SLEEP[2:0]] <= KSCN_SLEEP_RESET;
    end
    else if (got_byte && !first_q && ptr_q != KSCN_REG_QUEUE && ptr_q < 8'(KSCN_NREG))
      regs_q[ptr_q[2:0]] <= sh_q;
  end

  // Pop the queue when its byte is read
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      queue_pop_o <= 1'b0;
    else
      queue_pop_o <= tx_done && ptr_q == KSCN_REG_QUEUE;
  end

  // ---------------------------------------------------------------
  // SDA drive
  // ---------------------------------------------------------------
  // ack low on ninth clock; transmit bits MSB first
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      sda_oe_o <= 1'b0;
    else if (state_q == KSCN_ACK_RX)
      sda_oe_o <= 1'b1;
    else if (state_q == KSCN_TX)
      sda_oe_o <= !rd_data[3'(7 - bit_q)];
    else
      sda_oe_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      sda_o <= 1'b0;
    else
      sda_o <= 1'b0;  // Open drain only pulls low
  end

  // ---------------------------------------------------------------
  // Run bit: sleep and sequencer restart
  // ---------------------------------------------------------------
  kscn_wr_if ctl_if ();
  logic run_q, run_d1_q;

  // run bit is the awake state
  assign run_q = regs_q[KSCN_REG_CONFIG[2:0]][KSCN_CFG_RUN_BIT];

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      run_d1_q <= 1'b0;
      awake_o <= 1'b0;
    end
    else
    begin
      run_d1_q <= run_q;
      awake_o <= run_q;
    end
  end

  assign ctl_if.restart = run_q && !run_d1_q;
  assign ctl_if.awake = run_q;

  kscn_keydet u_keydet (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .key_sense_i(key_sense_i),
    .ctl(ctl_if.seq),
    .accepted_o(keys_o),
    .debounce_run_o(debounce_run_o)
  );
endmodule // kscn_i2c_port
`default_nettype wire

// [tb/kscn_monitor.sv]
// Checker on the pins of the key-scan register port.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module kscn_monitor
  import kscn_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic queue_pop_o,
  input wire logic awake_o,
  input wire logic [KSCN_ROWS*KSCN_COLS-1:0] key_sense_i,
  input wire logic [KSCN_ROWS*KSCN_COLS-1:0] keys_o,
  input wire logic debounce_run_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] ack_age_q;
  // Cycles since the device last pulled the data line
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || sda_oe_o)
      ack_age_q <= 8'h00;
    else if (ack_age_q != 8'hff)
      ack_age_q <= ack_age_q + 8'h01;
  end
  sequence s_asleep;
    !awake_o [*3];
  endsequence
  sequence s_no_keys;
    (key_sense_i == '0) [*3];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_sda_low;
    sda_o == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda_o not low");
  property p_oe_rise;
    $rose(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive began with scl high");
  property p_oe_fall;
    $fell(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("drive ended with scl high");
  property p_ghost;
    $countones({keys_o[9], keys_o[8], keys_o[1], keys_o[0]}) < 3;
  endproperty
  a_ghost: assert property (p_ghost) else $error("rectangle corners reported");
  property p_sleep_quiet;
    s_asleep |-> !debounce_run_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("debounce while asleep");
  property p_idle_quiet;
    s_no_keys |-> !debounce_run_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("debounce with no key");
  property p_pop_pulse;
    queue_pop_o |=> !queue_pop_o;
  endproperty
  a_pop_pulse: assert property (p_pop_pulse) else $error("pop longer than a cycle");
  property p_cfg_in_xfer;
    $changed(awake_o) |-> (ack_age_q < 8'd60) or (##[0:60] sda_oe_o);
  endproperty
  a_cfg_in_xfer: assert property (p_cfg_in_xfer) else $error("run bit moved off bus");
endmodule // kscn_monitor
bind kscn_i2c_port kscn_monitor kscn_monitor_inst (.clk_i(clk_i), .rstn_i(rstn_i),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .queue_pop_o(queue_pop_o),
  .awake_o(awake_o), .key_sense_i(key_sense_i), .keys_o(keys_o),
  .debounce_run_o(debounce_run_o));
`default_nettype wire

// [tb/kscn_master.sv]
// Bus master model driving clock and open-drain data.
// Assumes an external pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
module kscn_master
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Bus idle, both lines released
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Quarter bit, changes land just after an edge
  task automatic q();
    repeat (12) @(posedge clk_i);
    #1;
  endtask
  // One clock pulse, data line sampled while clock high
  task automatic bit_io(input logic b, output logic s);
    sda_o = b;
    q();
    scl_o = 1'b1;
    q();
    s = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // start also serves as repeated start
  task automatic start();
    sda_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b0;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_o = 1'b1;
    q();
  endtask
  // Byte out, most significant bit first, then ack slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // Byte in, then ack or no-ack from the master
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule // kscn_master
`default_nettype wire

// [tb/keyscan_i2c_register_port_test.sv]
// Self-checking bench for the key-scan register port.
// Assumes the master model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module keyscan_i2c_register_port_test;
  import kscn_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic scl, sda_m, sda_oe, sda_w, strap, pop, awake, dbr;
  logic [1:0] mode = 2'h0;
  logic [7:0] qd = 8'h2c;
  logic [63:0] sense = '0;
  logic [63:0] keys;
  logic [7:0] d;
  logic a;
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] rows [5] = '{16'h02a5, 16'h035a, 16'h063c, 16'h0180, 16'h04c3};
  // Open-drain wire and strap routing
  assign sda_w = sda_m & !sda_oe;
  assign strap = (mode == 2'h2) ? sda_w : (mode == 2'h3) ? scl : mode[0];
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  kscn_master kscn_master_inst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  kscn_i2c_port #(.TMO_CYC(200)) kscn_i2c_port_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .addr_strap_pin_i(strap),
    .strap_vcc_i(mode == 2'h1), .queue_data_i(qd), .key_sense_i(sense),
    .queue_pop_o(pop), .awake_o(awake), .keys_o(keys), .debounce_run_o(dbr));
  task automatic report_and_stop();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  // Byte out with the acknowledge checked
  task automatic wb(input logic [7:0] v);
    kscn_master_inst.wbyte(v, a);
    check("ack", 8'h01, {7'h0, a});
  endtask
  task automatic setp(input logic [7:0] p);
    kscn_master_inst.start();
    wb(8'h70);
    wb(p);
    kscn_master_inst.stop();
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    kscn_master_inst.start();
    wb(8'h70);
    wb(p);
    wb(v);
    kscn_master_inst.stop();
  endtask
  task automatic rd(input logic [7:0] e);
    kscn_master_inst.start();
    wb(8'h71);
    kscn_master_inst.rbyte(1'b1, d);
    kscn_master_inst.stop();
    check("read", e, d);
  endtask
  // Hang guard
  initial
  begin
    #400000;
    num_errors++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge clk_i);
    setp(8'h01);
    rd(KSCN_CFG_RESET);
    setp(8'h05);
    kscn_master_inst.start();
    wb(8'h71);
    kscn_master_inst.rbyte(1'b0, d);
    check("reg5", KSCN_REG_RESET, d);
    kscn_master_inst.rbyte(1'b0, d);
    check("reg6", KSCN_SLEEP_RESET, d);
    kscn_master_inst.rbyte(1'b1, d);
    check("wrap", qd, d);
    kscn_master_inst.stop();
    foreach (rows[i])
    begin
      wr(rows[i][15:8], rows[i][7:0]);
      setp(rows[i][15:8]);
      rd(rows[i][7:0]);
    end
    check("awake", 8'h01, {7'h0, awake});
    // Burst write over the wrap, read back with a repeated start
    kscn_master_inst.start();
    wb(8'h70);
    wb(8'h05);
    wb(8'h11);
    wb(8'h22);
    wb(8'h33);
    kscn_master_inst.stop();
    kscn_master_inst.start();
    wb(8'h70);
    wb(8'h05);
    kscn_master_inst.start();
    wb(8'h71);
    kscn_master_inst.rbyte(1'b0, d);
    check("b5", 8'h11, d);
    kscn_master_inst.rbyte(1'b0, d);
    check("b6", 8'h22, d);
    kscn_master_inst.rbyte(1'b1, d);
    check("b0", qd, d);
    kscn_master_inst.q();
    check("release", 8'h00, {7'h0, sda_oe});
    kscn_master_inst.stop();
    rd(qd);
    setp(8'h02);
    rd(8'ha5);
    // Every strap wiring answers its own address and not the one with both strap bits inverted
    for (int m = 0; m < 4; m++)
    begin
      mode = m[1:0];
      kscn_master_inst.start();
      wb({4'h7, m[1:0], 2'b00});
      kscn_master_inst.stop();
      kscn_master_inst.start();
      kscn_master_inst.wbyte({4'h7, ~m[1:0], 2'b00}, a);
      check("nack", 8'h00, {7'h0, a});
      kscn_master_inst.stop();
    end
    mode = 2'h0;
    // Sleep, wake and key sensing
    wr(8'h01, 8'h00);
    sense = 64'h1;
    repeat (10) @(posedge clk_i);
    #1;
    check("sleep", 8'h00, {6'h0, awake, dbr});
    wr(8'h01, 8'h80);
    repeat (10) @(posedge clk_i);
    #1;
    check("wake", 8'h03, {6'h0, awake, dbr});
    sense = 64'h0000_0000_0000_0003;
    repeat (20) @(posedge clk_i);
    #1;
    sense = 64'h0000_0000_0000_0303;
    repeat (20) @(posedge clk_i);
    #1;
    check("keys", 8'h03, keys[7:0]);
    check("ghost", 8'h00, keys[15:8]);
    sense = '0;
    // Bus held low past the timeout mid read
    wr(8'h01, 8'h81);
    setp(8'h02);
    kscn_master_inst.start();
    wb(8'h71);
    repeat (260) @(posedge clk_i);
    check("timeout", 8'h00, {7'h0, sda_oe});
    kscn_master_inst.stop();
    wr(8'h01, 8'h80);
    report_and_stop();
  end
endmodule // keyscan_i2c_register_port_test
`default_nettype wire
